// ---- hw/mcd_regs.sv ----
// Miscellaneous control and DRAM timing registers behind the sequencer port.
`timescale 1ns/100ps
`default_nettype none
// Function
// RL1 - Misc bit 6 set stops the cursor blinking and keeps it on.
// RL2 - Misc bit 5 clear drives user pin 1 from misc bit 4.
// RL3 - Misc bit 5 set drives user pin 1 from the signal picked by select 5:3.
// RL4 - Misc bit 3 clear drives user pin 0 from misc bit 2.
// RL5 - Misc bit 3 set drives user pin 0 from the signal picked by select 2:0.
// RL6 - Misc bit 1 set lets the host read registers hidden in compat modes.
// RL7 - Misc bit 0 set forces standard CPU addressing in 132-column text.
// RL8 - The DRAM timing register is read and written at index 13h.
// RL9 - DRAM timing bits 7:6 choose when zero-wait-state asserts.
// RL10 - Software must never write 00 into the zero-wait-state mode field.
// RL11 - DRAM timing holds CAS timing 4:3, CAS start 2, RAS precharge 1:0.
// RL12 - The misc register sits at index 12h and resets to zero.
// RL13 - Zero-wait asserts low per mode 01, 10 or 11 conditions.
// RL14 - CAS starts 1.5 clocks after RAS falls if bit 2 is set, else 2.5.
// RL15 - Reserved bits ignore writes and read as zero.
module mcd_regs (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic [7:0] seq_index_in,
  input wire logic [7:0] seq_wdata_in,
  input wire logic seq_wr_in,
  input wire logic seq_rd_in,
  input wire logic compat_mode_in,
  input wire logic [7:0] user_sig_in,
  input wire logic wbuf_ready_in,
  input wire logic mem_decoded_in,
  input wire logic memory_write_n_in,
  input wire logic io_write_in,
  input wire logic cursor_blink_in,
  output logic [7:0] seq_rdata_out,
  output logic seq_rvalid_out,
  output logic cursor_visible_out,
  output logic user_output_pin_0_out,
  output logic user_output_pin_1_out,
  output logic compat_readback_out,
  output logic std_addr_132_out,
  output logic zero_wait_state_n_out,
  output logic [1:0] cas_timing_out,
  output logic [2:0] cas_start_half_out,
  output logic [1:0] ras_precharge_out
);
  logic [7:0] misc_r;
  logic [7:0] dram_r;
  logic [7:0] osel_r;
  logic [7:0] user_sync1_r;
  logic [7:0] user_sync2_r;
  logic [4:0] zw_sync1_r;
  logic [4:0] zw_sync2_r;
  logic zw_assert;

  // Register writes; masks keep reserved bits at zero.
  always_ff @(posedge sys_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      misc_r <= mcd_pkg::MISC_CTRL_RESET; // RL12
      dram_r <= mcd_pkg::DRAM_TIMING_RESET;
      osel_r <= mcd_pkg::OUT_SELECT_RESET;
    end
    else if (seq_wr_in)
    begin
      if (seq_index_in == mcd_pkg::IDX_MISC_CTRL) // RL12
        misc_r <= seq_wdata_in & mcd_pkg::MISC_CTRL_MASK; // RL15
      if (seq_index_in == mcd_pkg::IDX_DRAM_TIMING) // RL8
        dram_r <= seq_wdata_in & mcd_pkg::DRAM_TIMING_MASK; // RL11 RL15
      if (seq_index_in == mcd_pkg::IDX_OUT_SELECT)
        osel_r <= seq_wdata_in & mcd_pkg::OUT_SELECT_MASK;
    end
  end

  // Readback; in a compatibility mode these registers hide unless enabled.
  always_ff @(posedge sys_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      seq_rdata_out <= 8'h00;
      seq_rvalid_out <= 1'b0;
    end
    else
    begin
      seq_rvalid_out <= seq_rd_in;
      seq_rdata_out <= 8'h00;
      if (seq_rd_in && (!compat_mode_in || misc_r[mcd_pkg::MC_READBACK])) // RL6
      begin
        case (seq_index_in)
          mcd_pkg::IDX_MISC_CTRL: seq_rdata_out <= misc_r;
          mcd_pkg::IDX_DRAM_TIMING: seq_rdata_out <= dram_r; // RL8
          mcd_pkg::IDX_OUT_SELECT: seq_rdata_out <= osel_r;
          default: seq_rdata_out <= 8'h00;
        endcase
      end
    end
  end

  // External status signals cross in through two flops each.
  always_ff @(posedge sys_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      user_sync1_r <= 8'h00;
      user_sync2_r <= 8'h00;
      zw_sync1_r <= 5'h00;
      zw_sync2_r <= 5'h00;
    end
    else
    begin
      user_sync1_r <= user_sig_in;
      user_sync2_r <= user_sync1_r;
      zw_sync1_r <= {cursor_blink_in, io_write_in, memory_write_n_in,
                     mem_decoded_in, wbuf_ready_in};
      zw_sync2_r <= zw_sync1_r;
    end
  end

  // Level for one user pin: the stored echo bit, or the watched signal that
  // the select code names while the pin's select bit is set.
  function automatic logic pin_level(
    input logic use_sig,
    input logic echo_val,
    input logic [2:0] code,
    input logic [7:0] sigs
  );
    logic level;
    level = echo_val; // RL2 RL4
    if (use_sig)
      level = sigs[code]; // RL3 RL5
    return level;
  endfunction

  // Zero-wait request for one mode, from the synchronised status word:
  // bit 0 write buffer ready, bit 1 address decoded, bit 2 memory write
  // (low active) and bit 3 I/O write.
  function automatic logic zw_request(
    input logic [1:0] mode,
    input logic [4:0] status
  );
    logic base;
    logic req;
    base = status[0] & status[1];
    case (mcd_pkg::mcd_zw_e'(mode))
      mcd_pkg::MCD_ZW_DEC: req = base; // RL13
      mcd_pkg::MCD_ZW_MWR: req = base & ~status[2]; // RL13
      mcd_pkg::MCD_ZW_IOW: req = (base & ~status[2]) | status[3]; // RL13
      // Mode 00 never asserts, the safe reading of a code that must not be
      // used, so a stray write cannot hold the host in zero-wait cycles.
      default: req = 1'b0; // RL10
    endcase
    return req;
  endfunction

  always_comb
  begin
    zw_assert = zw_request(dram_r[mcd_pkg::DT_ZW_HI:mcd_pkg::DT_ZW_LO],
                           zw_sync2_r); // RL9
  end

  // The cursor stays lit with blinking off; otherwise it follows the timer.
  always_ff @(posedge sys_clk_in or posedge rst_in)
  begin
    if (rst_in)
      cursor_visible_out <= 1'b0;
    else
      cursor_visible_out <= misc_r[mcd_pkg::MC_BLINK_OFF]
                            | zw_sync2_r[4]; // RL1
  end

  // User pins; a watched signal reaches its pin three edges after it moves.
  always_ff @(posedge sys_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      user_output_pin_0_out <= 1'b0;
      user_output_pin_1_out <= 1'b0;
    end
    else
    begin
      user_output_pin_1_out <= pin_level(misc_r[mcd_pkg::MC_PIN1_SEL],
        misc_r[mcd_pkg::MC_PIN1_VAL],
        osel_r[mcd_pkg::OS_PIN1_HI:mcd_pkg::OS_PIN1_LO],
        user_sync2_r); // RL2 RL3
      user_output_pin_0_out <= pin_level(misc_r[mcd_pkg::MC_PIN0_SEL],
        misc_r[mcd_pkg::MC_PIN0_VAL],
        osel_r[mcd_pkg::OS_PIN0_HI:mcd_pkg::OS_PIN0_LO],
        user_sync2_r); // RL4 RL5
    end
  end

  // Plain mirrors of the readback and addressing bits.
  always_ff @(posedge sys_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      compat_readback_out <= 1'b0;
      std_addr_132_out <= 1'b0;
    end
    else
    begin
      compat_readback_out <= misc_r[mcd_pkg::MC_READBACK]; // RL6
      std_addr_132_out <= misc_r[mcd_pkg::MC_STD_ADDR]; // RL7
    end
  end

  // The zero-wait pin idles high, so reset leaves it released.
  always_ff @(posedge sys_clk_in or posedge rst_in)
  begin
    if (rst_in)
      zero_wait_state_n_out <= 1'b1;
    else
      zero_wait_state_n_out <= ~zw_assert; // RL9
  end

  // DRAM timing fields; the CAS start is given in half memory clocks.
  always_ff @(posedge sys_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      cas_timing_out <= 2'h0;
      cas_start_half_out <= mcd_pkg::CAS_START_SLOW_HALF;
      ras_precharge_out <= 2'h0;
    end
    else
    begin
      cas_timing_out <= dram_r[mcd_pkg::DT_CAS_HI:mcd_pkg::DT_CAS_LO]; // RL11
      cas_start_half_out <= dram_r[mcd_pkg::DT_CAS_START]
                            ? mcd_pkg::CAS_START_FAST_HALF
                            : mcd_pkg::CAS_START_SLOW_HALF; // RL14
      ras_precharge_out <= dram_r[mcd_pkg::DT_RAS_HI:mcd_pkg::DT_RAS_LO];
    end
  end
endmodule
`default_nettype wire

// ---- common/mcd_pkg.sv ----
// Constants for the miscellaneous control and DRAM timing register pair.
package mcd_pkg;
  // Sequencer indices.
  localparam logic [7:0] IDX_MISC_CTRL = 8'h12;
  localparam logic [7:0] IDX_DRAM_TIMING = 8'h13;
  localparam logic [7:0] IDX_OUT_SELECT = 8'h15;
  // Reset values.
  localparam logic [7:0] MISC_CTRL_RESET = 8'h00;
  localparam logic [7:0] DRAM_TIMING_RESET = 8'hC0;
  localparam logic [7:0] OUT_SELECT_RESET = 8'h00;
  // Writable bit masks; reserved bits read zero.
  localparam logic [7:0] MISC_CTRL_MASK = 8'h7F;
  localparam logic [7:0] DRAM_TIMING_MASK = 8'hDF;
  localparam logic [7:0] OUT_SELECT_MASK = 8'h3F;
  // Miscellaneous control field positions.
  localparam int MC_BLINK_OFF = 6;
  localparam int MC_PIN1_SEL = 5;
  localparam int MC_PIN1_VAL = 4;
  localparam int MC_PIN0_SEL = 3;
  localparam int MC_PIN0_VAL = 2;
  localparam int MC_READBACK = 1;
  localparam int MC_STD_ADDR = 0;
  // DRAM timing field positions.
  localparam int DT_ZW_HI = 7;
  localparam int DT_ZW_LO = 6;
  localparam int DT_CAS_HI = 4;
  localparam int DT_CAS_LO = 3;
  localparam int DT_CAS_START = 2;
  localparam int DT_RAS_HI = 1;
  localparam int DT_RAS_LO = 0;
  // Output select field positions.
  localparam int OS_PIN1_HI = 5;
  localparam int OS_PIN1_LO = 3;
  localparam int OS_PIN0_HI = 2;
  localparam int OS_PIN0_LO = 0;
  // Zero-wait-state modes.
  typedef enum logic [1:0] {
    MCD_ZW_RSVD = 2'b00,
    MCD_ZW_DEC = 2'b01,
    MCD_ZW_MWR = 2'b10,
    MCD_ZW_IOW = 2'b11
  } mcd_zw_e;
  // CAS start delay in half memory clocks after RAS falls.
  localparam logic [2:0] CAS_START_FAST_HALF = 3'h3;
  localparam logic [2:0] CAS_START_SLOW_HALF = 3'h5;
endpackage

// ---- tb/mcd_checker.sv ----
// Checker for the register pair, bound to the top module.
`timescale 1ns/100ps
`default_nettype none
module mcd_checker (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic [7:0] seq_index_in,
  input wire logic [7:0] seq_wdata_in,
  input wire logic seq_wr_in,
  input wire logic seq_rd_in,
  input wire logic [7:0] seq_rdata_out,
  input wire logic seq_rvalid_out,
  input wire logic cursor_visible_out,
  input wire logic user_output_pin_0_out,
  input wire logic user_output_pin_1_out,
  input wire logic compat_readback_out,
  input wire logic std_addr_132_out,
  input wire logic [1:0] cas_timing_out,
  input wire logic [2:0] cas_start_half_out,
  input wire logic [1:0] ras_precharge_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  // Outputs settle two edges after a write, so the write is piped twice.
  logic [1:0] m1, m2;
  logic [7:0] d1, d2;
  always_ff @(posedge sys_clk_in or posedge rst_in)
    if (rst_in)
      {m2, m1, d2, d1} <= 20'h0;
    else
      {m2, m1, d2, d1} <= {m1, seq_wr_in && seq_index_in == 8'h13,
        seq_wr_in && seq_index_in == 8'h12, d1, seq_wdata_in};
  sequence s_unmapped;
    seq_rd_in && !(seq_index_in inside {8'h12, 8'h13, 8'h15});
  endsequence
  a_read_answer: assert property (seq_rd_in |=> seq_rvalid_out)
    else $error("no read answer");
  a_unmapped_zero: assert property (s_unmapped |=> !seq_rdata_out)
    else $error("unmapped read not zero");
  a_cas_start: assert property (m2[1] |->
    cas_start_half_out == (d2[2] ? 3'h3 : 3'h5)) else $error("cas start");
  a_dram_fields: assert property (m2[1] |->
    {cas_timing_out, ras_precharge_out} == {d2[4:3], d2[1:0]})
    else $error("dram fields");
  a_misc_flags: assert property (m2[0] |->
    {compat_readback_out, std_addr_132_out} == d2[1:0]) else $error("flags");
  a_blink_off: assert property (m2[0] && d2[6] |-> cursor_visible_out)
    else $error("cursor blinks");
  a_pin0_echo: assert property (m2[0] && !d2[3] |->
    user_output_pin_0_out == d2[2]) else $error("pin 0 echo");
  a_pin1_echo: assert property (m2[0] && !d2[5] |->
    user_output_pin_1_out == d2[4]) else $error("pin 1 echo");
endmodule
bind mcd_regs mcd_checker u_chk (.*);
`default_nettype wire

// ---- tb/mcd_host.sv ----
// Host CPU model driving the sequencer index and data ports.
`timescale 1ns/100ps
`default_nettype none
module mcd_host (
  input wire logic clk_in,
  output logic [7:0] idx_out,
  output logic [7:0] wdata_out,
  output logic wr_out,
  output logic rd_out,
  input wire logic [7:0] rdata_in
);
  initial {idx_out, wdata_out, wr_out, rd_out} = 18'h0;
  task automatic put(input logic [7:0] i, d, input logic w);
    @(posedge clk_in);
    idx_out <= i;
    wdata_out <= w ? d : ~wdata_out;
    {wr_out, rd_out} <= {w, !w};
    @(posedge clk_in);
    {wr_out, rd_out} <= 2'h0;
  endtask
  task automatic get(input logic [7:0] i, output logic [7:0] d);
    put(i, 8'h00, 1'b0);
    @(posedge clk_in);
    d = rdata_in;
  endtask
endmodule
`default_nettype wire

// ---- tb/test_misc_control_and_dram_timing_regs.sv ----
// Self-checking bench for the register pair.
`timescale 1ns/100ps
`default_nettype none
module test_misc_control_and_dram_timing_regs;
  logic clk = 1'b0, rst = 1'b1, cm = 1'b0, wb = 1'b0, dec = 1'b0;
  logic mw_n = 1'b1, iow = 1'b0, bl = 1'b0, wr, rd, rv, cv, p0, p1, cr, sa, zw;
  logic [7:0] us = 8'h00, idx, wd, rdat, mc, dt, os, got;
  logic [1:0] ct, rp;
  logic [2:0] cs;
  int bad_count = 0, check_count = 0, cyc = 0;
  always #50 clk = ~clk;
  mcd_host host (.clk_in(clk), .idx_out(idx), .wdata_out(wd), .wr_out(wr),
    .rd_out(rd), .rdata_in(rdat));
  mcd_regs dut (.sys_clk_in(clk), .rst_in(rst), .seq_index_in(idx),
    .seq_wdata_in(wd), .seq_wr_in(wr), .seq_rd_in(rd), .compat_mode_in(cm),
    .user_sig_in(us), .wbuf_ready_in(wb), .mem_decoded_in(dec),
    .memory_write_n_in(mw_n), .io_write_in(iow), .cursor_blink_in(bl),
    .seq_rdata_out(rdat), .seq_rvalid_out(rv), .cursor_visible_out(cv),
    .user_output_pin_0_out(p0), .user_output_pin_1_out(p1),
    .compat_readback_out(cr), .std_addr_132_out(sa),
    .zero_wait_state_n_out(zw), .cas_timing_out(ct),
    .cas_start_half_out(cs), .ras_precharge_out(rp));
  task automatic cmp(input logic [7:0] g, e);
    check_count++;
    if (g !== e)
    begin
      bad_count++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic conclude;
    if (bad_count == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Each pass takes about 23 cycles; the ceiling leaves ample slack.
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 6000)
    begin
      bad_count++;
      conclude;
    end
  end
  function automatic logic [7:0] vis(input logic [7:0] v, m);
    return cm && !mc[1] ? 8'h00 : v & m;
  endfunction
  function automatic logic zwx();
    logic c;
    c = wb && dec && (dt[7:6] == 2'b01 || !mw_n);
    return dt[7:6] == 2'b11 ? c || iow : c;
  endfunction
  initial
  begin
    void'($urandom(32'hFBB607E6));
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    mc = 8'h00;
    host.get(8'h12, got); cmp(got, 8'h00);
    host.get(8'h13, got); cmp(got, 8'hC0);
    cmp({cv, p0, p1, cr, sa}, 5'h00);
    cmp({zw, cs}, {1'b1, 3'h5});
    repeat (60)
    begin
      {mc, dt, os} = 24'($urandom);
      us <= 8'($urandom);
      if (dt[7:6] == 2'b00) dt[7:6] = 2'b11;
      @(posedge clk);
      {cm, wb, dec, mw_n, iow, bl} <= 6'($urandom);
      host.put(8'h12, mc, 1'b1);
      host.put(8'h13, dt, 1'b1);
      host.put(8'h15, os, 1'b1);
      repeat (4) @(posedge clk);
      cmp(cv, mc[6] | bl);
      cmp(p1, mc[5] ? us[os[5:3]] : mc[4]);
      cmp(p0, mc[3] ? us[os[2:0]] : mc[2]);
      cmp({cr, sa}, mc[1:0]);
      cmp(zw, !zwx());
      cmp({ct, cs, rp}, {dt[4:3], dt[2] ? 3'h3 : 3'h5, dt[1:0]});
      host.get(8'h12, got); cmp(got, vis(mc, 8'h7F));
      host.get(8'h13, got); cmp(got, vis(dt, 8'hDF));
      host.get(8'h15, got); cmp(got, vis(os, 8'h3F));
      host.get(8'h14, got); cmp(got, 8'h00);
    end
    conclude;
  end
endmodule
`default_nettype wire
